// file: logic/control_cycle_divider.sv
// divider producing the one-cycle control-cycle enable
// assumes one system clock and a synchronous active-high reset
`default_nettype none

module control_cycle_divider #(
    parameter int DIV = 20
) (
    input wire logic sys_clk, // system clock
    input wire logic reset, // synchronous reset
    output logic tick // one-cycle enable per control cycle
);

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    localparam int CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    logic [CNT_W-1:0] count;
    wire wrap = (count == LAST);

    // count through the cycle and pulse on wrap
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= wrap ? '0 : count + ONE;
            tick <= wrap;
        end
    end

endmodule // control_cycle_divider

`default_nettype wire

// file: logic/flag_pkg.sv
// constants, register map and mode encodings for the servo status flag block
// assumes a classic wishbone slave with 32-bit data and byte addresses
`default_nettype none

package flag_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int POS_W = 32;
    localparam int WIN_W = 31;
    localparam int SPD_W = 14;
    localparam int SPD_IN_W = 16;
    localparam int FLAG_N = 3;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_DONE_WINDOW = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_CLOSE_WINDOW = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_CONFIG = 6'h0C;
    localparam logic [ADDR_W-1:0] OFF_TORQUE_CAP = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_ALLOC = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 6'h1C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 6'h20;
    localparam logic [ADDR_W-1:0] OFF_CONFIG_ACTIVE = 6'h24;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RESTART_BIT = 4;
    localparam int CFG_TIMING_LSB = 0;
    localparam int CFG_SOURCE_BIT = 4;
    localparam int CFG_CEILING_BIT = 8;
    localparam int FLAG_DONE = 0;
    localparam int FLAG_CLOSE = 1;
    localparam int FLAG_CLAMP = 2;
    localparam int STAT_ENFORCE_BIT = 4;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [WIN_W-1:0] DONE_WINDOW_RST = 31'h0000_0007;
    localparam logic [WIN_W-1:0] CLOSE_WINDOW_RST = 31'h4000_0000;
    localparam logic [SPD_W-1:0] TORQUE_CAP_RST = 14'h2710;
    localparam logic [FLAG_N-1:0] ALLOC_RST = 3'h0;
    localparam logic [FLAG_N-1:0] MASK_RST = 3'h0;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_POSITION = 2'h0,
        MODE_SPEED = 2'h1,
        MODE_TORQUE = 2'h3
    } control_mode_t;

    typedef enum logic [1:0] {
        TIMING_ERROR_ONLY = 2'h0,
        TIMING_FILTERED_ZERO = 2'h1,
        TIMING_RAW_ZERO = 2'h2
    } done_timing_t;

    localparam int CYCLE_DIV_DEFAULT = 20;

endpackage

`default_nettype wire

// file: logic/servo_status_flags.sv
// position window, near window and torque-mode speed clamp flags
// assumes drive signals on sys_clk and a classic wishbone master
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`default_nettype none

module servo_status_flags #(
    parameter int CYCLE_DIV = flag_pkg::CYCLE_DIV_DEFAULT
) (
    input wire logic sys_clk, // system clock
    input wire logic reset, // synchronous reset
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [flag_pkg::ADDR_W-1:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic [flag_pkg::POS_W-1:0] ref_count, // host reference count
    input wire logic [flag_pkg::POS_W-1:0] motor_travel, // motor travel count
    input wire logic [flag_pkg::POS_W-1:0] filtered_ref_step, // filtered reference step
    input wire logic [flag_pkg::POS_W-1:0] raw_ref_step, // raw reference step
    input wire logic [flag_pkg::SPD_IN_W-1:0] motor_speed, // signed motor speed
    input wire logic [flag_pkg::SPD_W-1:0] max_motor_speed, // motor top speed
    input wire logic [flag_pkg::SPD_W-1:0] overspeed_speed, // overspeed trip speed
    input wire logic [flag_pkg::SPD_W-1:0] host_speed_cap, // host speed limit
    output logic positioning_done_out, // done flag
    output logic positioning_done_oe, // done flag driven
    output logic positioning_close_out, // near flag
    output logic positioning_close_oe, // near flag driven
    output logic speed_clamp_active_out, // clamp flag
    output logic speed_clamp_active_oe, // clamp flag driven
    output logic [flag_pkg::SPD_W-1:0] speed_limit, // active speed limit
    output logic speed_limit_enable, // limit enforced
    output logic irq // level interrupt
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // magnitude of a two's complement word
    function automatic logic [flag_pkg::POS_W-1:0] magnitude(
        input logic [flag_pkg::POS_W-1:0] v
    );
        magnitude = v[flag_pkg::POS_W-1] ? flag_pkg::POS_W'(~v + 1'b1) : v;
    endfunction

    // byte-lane merge of a write into a register word
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // word decode of a byte offset
    function automatic logic hit(
        input logic [flag_pkg::ADDR_W-1:0] adr,
        input logic [flag_pkg::ADDR_W-1:0] off
    );
        hit = (adr[flag_pkg::ADDR_W-1:2] == off[flag_pkg::ADDR_W-1:2]);
    endfunction

    // ----------------------------------------------------------------
    // control cycle enable
    // ----------------------------------------------------------------
    logic tick;

    control_cycle_divider #(
        .DIV(CYCLE_DIV)
    ) u_divider (
        .sys_clk(sys_clk),
        .reset(reset),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    flag_pkg::control_mode_t control_mode;
    logic [flag_pkg::WIN_W-1:0] done_window_param;
    logic [flag_pkg::WIN_W-1:0] close_window_param;
    logic [1:0] pend_timing;
    logic pend_source;
    logic pend_ceiling;
    flag_pkg::done_timing_t done_timing_param;
    logic speed_cap_source_param;
    logic cap_ceiling_select_param;
    logic [flag_pkg::SPD_W-1:0] torque_mode_speed_cap_param;
    logic [flag_pkg::FLAG_N-1:0] alloc;
    logic [flag_pkg::FLAG_N-1:0] irq_status;
    logic [flag_pkg::FLAG_N-1:0] irq_mask;
    logic [flag_pkg::FLAG_N-1:0] flags;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------

    // one access per request, answered the next cycle
    wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = access & wb_we_i;
    wire wr_control = wr & hit(wb_adr_i, flag_pkg::OFF_CONTROL);
    wire wr_done_win = wr & hit(wb_adr_i, flag_pkg::OFF_DONE_WINDOW);
    wire wr_close_win = wr & hit(wb_adr_i, flag_pkg::OFF_CLOSE_WINDOW);
    wire wr_config = wr & hit(wb_adr_i, flag_pkg::OFF_CONFIG);
    wire wr_cap = wr & hit(wb_adr_i, flag_pkg::OFF_TORQUE_CAP);
    wire wr_alloc = wr & hit(wb_adr_i, flag_pkg::OFF_ALLOC);
    wire wr_irq_status = wr & hit(wb_adr_i, flag_pkg::OFF_IRQ_STATUS);
    wire wr_irq_mask = wr & hit(wb_adr_i, flag_pkg::OFF_IRQ_MASK);

    // current register words for merging and readback
    wire [31:0] control_word = {30'h0, control_mode};
    wire [31:0] done_win_word = {1'b0, done_window_param};
    wire [31:0] close_win_word = {1'b0, close_window_param};
    wire [31:0] pend_word = {23'h0, pend_ceiling, 3'h0, pend_source, 2'h0, pend_timing};
    wire [31:0] active_word = {23'h0, cap_ceiling_select_param, 3'h0,
                               speed_cap_source_param, 2'h0, done_timing_param};
    wire [31:0] cap_word = {18'h0, torque_mode_speed_cap_param};
    wire [31:0] alloc_word = {29'h0, alloc};
    wire [31:0] status_word = {27'h0, speed_limit_enable, 1'b0, flags};
    wire [31:0] irq_status_word = {29'h0, irq_status};
    wire [31:0] irq_mask_word = {29'h0, irq_mask};

    // merged write values
    wire [31:0] control_new = merge(control_word, wb_dat_i, wb_sel_i);
    wire [31:0] done_win_new = merge(done_win_word, wb_dat_i, wb_sel_i);
    wire [31:0] close_win_new = merge(close_win_word, wb_dat_i, wb_sel_i);
    wire [31:0] config_new = merge(pend_word, wb_dat_i, wb_sel_i);
    wire [31:0] cap_new = merge(cap_word, wb_dat_i, wb_sel_i);
    wire [31:0] alloc_new = merge(alloc_word, wb_dat_i, wb_sel_i);
    wire [31:0] mask_new = merge(irq_mask_word, wb_dat_i, wb_sel_i);
    wire [31:0] clear_bits = merge(32'h0000_0000, wb_dat_i, wb_sel_i);

    // restart request loads the pending configuration
    wire restart = wr_control & wb_sel_i[0] & wb_dat_i[flag_pkg::CTRL_RESTART_BIT];

    // read selection, zero for unmapped words
    wire [31:0] next_rdata =
        hit(wb_adr_i, flag_pkg::OFF_CONTROL) ? control_word :
        hit(wb_adr_i, flag_pkg::OFF_DONE_WINDOW) ? done_win_word :
        hit(wb_adr_i, flag_pkg::OFF_CLOSE_WINDOW) ? close_win_word :
        hit(wb_adr_i, flag_pkg::OFF_CONFIG) ? pend_word :
        hit(wb_adr_i, flag_pkg::OFF_TORQUE_CAP) ? cap_word :
        hit(wb_adr_i, flag_pkg::OFF_ALLOC) ? alloc_word :
        hit(wb_adr_i, flag_pkg::OFF_STATUS) ? status_word :
        hit(wb_adr_i, flag_pkg::OFF_IRQ_STATUS) ? irq_status_word :
        hit(wb_adr_i, flag_pkg::OFF_IRQ_MASK) ? irq_mask_word :
        hit(wb_adr_i, flag_pkg::OFF_CONFIG_ACTIVE) ? active_word : 32'h0000_0000;

    // ----------------------------------------------------------------
    // bus answer
    // ----------------------------------------------------------------

    // ack and read data one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            wb_dat_o <= (access & ~wb_we_i) ? next_rdata : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // immediate parameters
    // ----------------------------------------------------------------

    // windows, cap, allocation and mode take effect at once
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            control_mode <= flag_pkg::MODE_POSITION;
            done_window_param <= flag_pkg::DONE_WINDOW_RST;
            close_window_param <= flag_pkg::CLOSE_WINDOW_RST;
            torque_mode_speed_cap_param <= flag_pkg::TORQUE_CAP_RST;
            alloc <= flag_pkg::ALLOC_RST;
            irq_mask <= flag_pkg::MASK_RST;
        end else begin
            if (wr_control) begin
                control_mode <= flag_pkg::control_mode_t'(control_new[1:0]);
            end
            if (wr_done_win) begin
                done_window_param <= done_win_new[flag_pkg::WIN_W-1:0];
            end
            if (wr_close_win) begin
                close_window_param <= close_win_new[flag_pkg::WIN_W-1:0];
            end
            if (wr_cap) begin
                torque_mode_speed_cap_param <= cap_new[flag_pkg::SPD_W-1:0];
            end
            if (wr_alloc) begin
                alloc <= alloc_new[flag_pkg::FLAG_N-1:0];
            end
            if (wr_irq_mask) begin
                irq_mask <= mask_new[flag_pkg::FLAG_N-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // restart-time parameters
    // ----------------------------------------------------------------

    // pending copy written freely, active copy loaded on restart
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pend_timing <= flag_pkg::TIMING_ERROR_ONLY;
            pend_source <= 1'b0;
            pend_ceiling <= 1'b0;
            done_timing_param <= flag_pkg::TIMING_ERROR_ONLY;
            speed_cap_source_param <= 1'b0;
            cap_ceiling_select_param <= 1'b0;
        end else begin
            if (wr_config) begin
                pend_timing <= config_new[flag_pkg::CFG_TIMING_LSB +: 2];
                pend_source <= config_new[flag_pkg::CFG_SOURCE_BIT];
                pend_ceiling <= config_new[flag_pkg::CFG_CEILING_BIT];
            end
            if (restart) begin
                done_timing_param <= flag_pkg::done_timing_t'(pend_timing);
                speed_cap_source_param <= pend_source;
                cap_ceiling_select_param <= pend_ceiling;
            end
        end
    end

    // ----------------------------------------------------------------
    // position window compare
    // ----------------------------------------------------------------

    // absolute position error against both windows
    wire [flag_pkg::POS_W-1:0] pos_error = flag_pkg::POS_W'(ref_count - motor_travel);
    wire [flag_pkg::POS_W-1:0] error_mag = magnitude(pos_error);
    wire below_done = error_mag < {1'b0, done_window_param};
    wire below_close = error_mag < {1'b0, close_window_param};
    wire position_mode = (control_mode == flag_pkg::MODE_POSITION);
    wire torque_mode = (control_mode == flag_pkg::MODE_TORQUE);

    // extra qualifier chosen by the done timing setting
    wire timing_ok =
        (done_timing_param == flag_pkg::TIMING_FILTERED_ZERO) ? (filtered_ref_step == '0) :
        (done_timing_param == flag_pkg::TIMING_RAW_ZERO) ? (raw_ref_step == '0) :
        1'b1;

    wire next_done = position_mode & below_done & timing_ok;
    wire next_close = below_close;

    // ----------------------------------------------------------------
    // speed limit
    // ----------------------------------------------------------------

    // internal limit bounded by motor top speed or overspeed trip
    wire [flag_pkg::SPD_W-1:0] ceiling = cap_ceiling_select_param ? overspeed_speed
                                                                  : max_motor_speed;
    wire [flag_pkg::SPD_W-1:0] internal_cap =
        (torque_mode_speed_cap_param < ceiling) ? torque_mode_speed_cap_param : ceiling;
    wire [flag_pkg::SPD_W-1:0] next_limit = speed_cap_source_param ? host_speed_cap
                                                                   : internal_cap;

    // speed magnitude widened to the error width
    wire [flag_pkg::POS_W-1:0] speed_word =
        {{(flag_pkg::POS_W - flag_pkg::SPD_IN_W){motor_speed[flag_pkg::SPD_IN_W-1]}},
         motor_speed};
    wire [flag_pkg::POS_W-1:0] speed_mag = magnitude(speed_word);
    wire at_limit = speed_mag >= {{(flag_pkg::POS_W - flag_pkg::SPD_W){1'b0}}, next_limit};
    wire next_clamp = torque_mode & at_limit;

    wire [flag_pkg::FLAG_N-1:0] next_flags = {next_clamp, next_close, next_done};

    // ----------------------------------------------------------------
    // flag evaluation
    // ----------------------------------------------------------------

    // flags and limit refreshed once per control cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flags <= '0;
            speed_limit <= flag_pkg::TORQUE_CAP_RST;
            speed_limit_enable <= 1'b0;
        end else if (tick) begin
            flags <= next_flags;
            speed_limit <= next_limit;
            speed_limit_enable <= torque_mode;
        end
    end

    // ----------------------------------------------------------------
    // output pins
    // ----------------------------------------------------------------

    // allocation gates each flag onto its pin
    wire [flag_pkg::FLAG_N-1:0] pin_flags = alloc & flags;

    // allocated flags drive high when true, unallocated stay released
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            positioning_done_out <= 1'b0;
            positioning_done_oe <= 1'b0;
            positioning_close_out <= 1'b0;
            positioning_close_oe <= 1'b0;
            speed_clamp_active_out <= 1'b0;
            speed_clamp_active_oe <= 1'b0;
        end else begin
            positioning_done_out <= pin_flags[flag_pkg::FLAG_DONE];
            positioning_done_oe <= alloc[flag_pkg::FLAG_DONE];
            positioning_close_out <= pin_flags[flag_pkg::FLAG_CLOSE];
            positioning_close_oe <= alloc[flag_pkg::FLAG_CLOSE];
            speed_clamp_active_out <= pin_flags[flag_pkg::FLAG_CLAMP];
            speed_clamp_active_oe <= alloc[flag_pkg::FLAG_CLAMP];
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------

    // rising flags are events; a set in the clearing cycle wins
    wire [flag_pkg::FLAG_N-1:0] events = tick ? (next_flags & ~flags) : '0;
    wire [flag_pkg::FLAG_N-1:0] clears = wr_irq_status ? clear_bits[flag_pkg::FLAG_N-1:0] : '0;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~clears) | events;
            irq <= |(((irq_status & ~clears) | events) & irq_mask);
        end
    end

endmodule // servo_status_flags

`default_nettype wire

// file: tb/servo_host_model.sv
// host model: reference and travel counts holding a chosen position error
// assumes the bench sets the wanted error; counts move on sys_clk
`default_nettype none
module servo_host_model (
    input wire logic sys_clk, // clock
    input wire logic [31:0] err, // wanted position error
    output logic [31:0] ref_count, // reference count
    output logic [31:0] motor_travel // travel count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] base = 32'h7FFF_FFF0;
    // both counts advance together, so the error holds across the wrap
    always @(posedge sys_clk) base <= base + 32'h3;
    assign ref_count = base + err;
    assign motor_travel = base;
endmodule // servo_host_model
`default_nettype wire

// file: tb/servo_status_flags_assertions.sv
// checker on the ports of the servo status flag block
// assumes it is bound onto the block, CYCLE_DIV of 2 or more
`default_nettype none
module servo_status_flags_assertions (
    input wire logic sys_clk, // clock
    input wire logic reset, // sync reset
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_ack_o, // acknowledge
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic positioning_done_out, // done flag
    input wire logic positioning_done_oe, // done driven
    input wire logic positioning_close_out, // near flag
    input wire logic positioning_close_oe, // near driven
    input wire logic speed_clamp_active_out, // clamp flag
    input wire logic speed_clamp_active_oe, // clamp driven
    input wire logic [flag_pkg::SPD_W-1:0] speed_limit, // active limit
    input wire logic irq // interrupt
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // bus answer shape
    property p_ack_lat;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack late");
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_dat_zero;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_zero: assert property (p_dat_zero) else $error("data without ack");
    // state right after reset
    property p_reset_val;
        $past(reset) |-> !irq && !positioning_done_out && speed_limit == 14'h2710;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("bad reset state");
    // unallocated pins stay off
    property p_done_oe;
        !positioning_done_oe |-> !positioning_done_out;
    endproperty
    a_done_oe: assert property (p_done_oe) else $error("done pin undriven");
    property p_close_oe;
        !positioning_close_oe |-> !positioning_close_out;
    endproperty
    a_close_oe: assert property (p_close_oe) else $error("near pin undriven");
    property p_clamp_oe;
        !speed_clamp_active_oe |-> !speed_clamp_active_out;
    endproperty
    a_clamp_oe: assert property (p_clamp_oe) else $error("clamp pin undriven");
    // near flag holds at least the cycle after it rises
    property p_close_hold;
        $rose(positioning_close_out) |=>
            $stable(positioning_close_out) || $fell(positioning_close_oe);
    endproperty
    a_close_hold: assert property (p_close_hold) else $error("near flag glitch");
    c_done: cover property (positioning_done_out);
    c_clamp: cover property (speed_clamp_active_out);
    c_irq: cover property (irq);
endmodule // servo_status_flags_assertions
`default_nettype wire

// file: tb/servo_status_flags_tb.sv
// bench for the servo status flag block: bus tasks and flag scenarios
// assumes the host model drives the counts and the checker is bound
`default_nettype none
module servo_status_flags_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, err = 32'hA, filtered_ref_step = 32'h0, raw_ref_step = 32'h0;
    logic [31:0] wb_dat_o, ref_count, motor_travel, rd;
    logic [15:0] motor_speed = 16'h0000;
    logic [13:0] max_motor_speed = 14'h3FFF, overspeed_speed = 14'h3FFF;
    logic [13:0] host_speed_cap = 14'h0064, speed_limit;
    logic wb_ack_o, positioning_done_out, positioning_done_oe, positioning_close_out;
    logic positioning_close_oe, speed_clamp_active_out, speed_clamp_active_oe;
    logic speed_limit_enable, irq;
    int error_cnt = 0, total_checks = 0;
    wire logic [5:0] pins = {speed_clamp_active_oe, positioning_close_oe, positioning_done_oe,
        speed_clamp_active_out, positioning_close_out, positioning_done_out};
    always #25 sys_clk = ~sys_clk;
    servo_host_model u_host (.sys_clk, .err, .ref_count, .motor_travel);
    servo_status_flags #(.CYCLE_DIV(2)) u_dut (
        .sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .ref_count, .motor_travel, .filtered_ref_step, .raw_ref_step,
        .motor_speed, .max_motor_speed, .overspeed_speed, .host_speed_cap,
        .positioning_done_out, .positioning_done_oe, .positioning_close_out,
        .positioning_close_oe, .speed_clamp_active_out, .speed_clamp_active_oe,
        .speed_limit, .speed_limit_enable, .irq
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one classic cycle, held until ack, then one idle cycle
    task automatic bus(input logic we, input logic [5:0] adr, input logic [31:0] dat);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++) @(posedge sys_clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
        if (n == 50) begin
            check(32'h0, 32'h1);
            test_done();
        end
    endtask
    task automatic rdc(input logic [5:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        check(rd, exp);
    endtask
    // three control cycles pass, then the pins are compared
    task automatic flags(input logic [5:0] exp);
        repeat (6) @(posedge sys_clk);
        check(pins, exp);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rdc(flag_pkg::OFF_DONE_WINDOW, 32'h7);
        rdc(flag_pkg::OFF_CLOSE_WINDOW, 32'h4000_0000);
        rdc(flag_pkg::OFF_TORQUE_CAP, 32'h2710);
        rdc(6'h3C, 32'h0);
        flags(6'h00);
        bus(1'b1, flag_pkg::OFF_CLOSE_WINDOW, 32'h10);
        bus(1'b1, flag_pkg::OFF_ALLOC, 32'h7);
        bus(1'b1, flag_pkg::OFF_IRQ_MASK, 32'h1);
        flags(6'h3A);
        err <= 32'hFFFF_FFFA;
        flags(6'h3B);
        check(irq, 1'b1);
        bus(1'b0, flag_pkg::OFF_IRQ_STATUS, 32'h0);
        check(rd[0], 1'b1);
        bus(1'b1, flag_pkg::OFF_IRQ_MASK, 32'h0);
        flags(6'h3B);
        check(irq, 1'b0);
        bus(1'b1, flag_pkg::OFF_IRQ_STATUS, 32'h7);
        bus(1'b1, flag_pkg::OFF_IRQ_MASK, 32'h1);
        flags(6'h3B);
        check(irq, 1'b0);
        err <= 32'h7;
        flags(6'h3A);
        err <= 32'h10;
        flags(6'h38);
        err <= 32'h0;
        bus(1'b1, flag_pkg::OFF_CONTROL, 32'h1);
        flags(6'h3A);
        bus(1'b1, flag_pkg::OFF_CONTROL, 32'h0);
        flags(6'h3B);
        for (int t = 1; t <= 2; t++) begin
            bus(1'b1, flag_pkg::OFF_CONFIG, t);
            bus(1'b1, flag_pkg::OFF_CONTROL, 32'h10);
            rdc(flag_pkg::OFF_CONFIG_ACTIVE, t);
            filtered_ref_step <= (t == 2) ? 32'h5 : 32'h0;
            raw_ref_step <= (t == 1) ? 32'h5 : 32'h0;
            flags(6'h3B);
            filtered_ref_step <= raw_ref_step;
            raw_ref_step <= filtered_ref_step;
            flags(6'h3A);
        end
        bus(1'b1, flag_pkg::OFF_CONFIG, 32'h0);
        bus(1'b1, flag_pkg::OFF_TORQUE_CAP, 32'h1F4);
        bus(1'b1, flag_pkg::OFF_CONTROL, 32'h13);
        motor_speed <= 16'hFDA8;
        flags(6'h3E);
        check(speed_limit, 32'h1F4);
        check(speed_limit_enable, 1'b1);
        rdc(flag_pkg::OFF_STATUS, 32'h16);
        motor_speed <= 16'h01F3;
        flags(6'h3A);
        max_motor_speed <= 14'h012C;
        overspeed_speed <= 14'h00C8;
        bus(1'b1, flag_pkg::OFF_CONFIG, 32'h100);
        flags(6'h3E);
        check(speed_limit, 32'h12C);
        bus(1'b1, flag_pkg::OFF_CONTROL, 32'h13);
        flags(6'h3E);
        check(speed_limit, 32'hC8);
        bus(1'b1, flag_pkg::OFF_CONFIG, 32'h110);
        bus(1'b1, flag_pkg::OFF_CONTROL, 32'h13);
        motor_speed <= 16'h0063;
        flags(6'h3A);
        check(speed_limit, 32'h64);
        bus(1'b1, flag_pkg::OFF_CONTROL, 32'h0);
        flags(6'h3B);
        check(speed_limit_enable, 1'b0);
        bus(1'b1, flag_pkg::OFF_ALLOC, 32'h2);
        flags(6'h12);
        test_done();
    end
endmodule // servo_status_flags_tb
bind servo_status_flags servo_status_flags_assertions u_chk (
    .sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .positioning_done_out,
    .positioning_done_oe, .positioning_close_out, .positioning_close_oe,
    .speed_clamp_active_out, .speed_clamp_active_oe, .speed_limit, .irq
);
`default_nettype wire
